// ==== src/pwmrt_core.sv ====
// Configuration registers of the audio processing path: fourth channel
// source, PWM output crossbar, compressor enables, switching-rate code.
// Assumes a register port already decoded from the serial control port,
// and all inputs synchronous to mclk.
//
// Operation
// - D8 picks left post-biquad or L/R average
// - Any PWM channel may drive any pin
// - Pins A,B,C use bits 21:20,17:16,13:12
// - Pin D uses bits 9:8
// - Code 0 is channel 1, 1 channel 2
// - Reset routing: A=00, B=10, C=01, D=11
// - Codes 10 and 11 give channels 1, 2
// - Second compressor runs only while D1 set
// - First compressor runs only while D0 set
// - Rate code D3:D0, only 6 to 9 valid
`include "pwmrt_regs.svh"

module pwmrt_core (
   // Clock and reset
   input  wire logic                   mclk,
   input  wire logic                   rst,
   // Register port
   input  wire logic                   reg_wr,
   input  wire logic                   reg_rd,
   input  wire logic [7:0]             reg_addr,
   input  wire logic [31:0]            reg_wdata,
   output logic      [31:0]            reg_rdata_q,
   output logic                        reg_ack_q,
   // Audio samples after the biquad stages
   input  wire logic                   sample_valid,
   input  wire pwmrt_pkg::pwmrt_sample_t left_post_bq,
   input  wire pwmrt_pkg::pwmrt_sample_t right_post_bq,
   output pwmrt_pkg::pwmrt_sample_t    fourth_channel_q,
   // Internal PWM channels and output pins
   input  wire logic [1:0]             pwm_ch,
   output logic      [3:0]             out_pin_q,
   // Compressors and modulator
   input  wire logic                   all_shutdown,
   output logic                        first_compressor_q,
   output logic                        second_compressor_q,
   output logic      [3:0]             switching_rate_code_q,
   output logic                        rate_code_bad_q
);
   import pwmrt_pkg::*;

   pwmrt_state_t s_q;
   pwmrt_state_t s_d;
   logic [3:0]   pin_sel;
   logic [24:0]  sum_wide;
   logic [3:0]   rate_wr;
   logic         rate_ok;

   // One selector per pin, each reading its own field
   pwmrt_pin_sel u_sel_a (
      .code (s_q.xbar[`PWMRT_XBAR_A_LSB +: 2]),
      .ch   (pwm_ch),
      .pin  (pin_sel[0])
   );
   pwmrt_pin_sel u_sel_b (
      .code (s_q.xbar[`PWMRT_XBAR_B_LSB +: 2]),
      .ch   (pwm_ch),
      .pin  (pin_sel[1])
   );
   pwmrt_pin_sel u_sel_c (
      .code (s_q.xbar[`PWMRT_XBAR_C_LSB +: 2]),
      .ch   (pwm_ch),
      .pin  (pin_sel[2])
   );
   pwmrt_pin_sel u_sel_d (
      .code (s_q.xbar[`PWMRT_XBAR_D_LSB +: 2]),
      .ch   (pwm_ch),
      .pin  (pin_sel[3])
   );

   // Sign-extended sum keeps the carry, so the average cannot wrap
   assign sum_wide = {left_post_bq[23], left_post_bq}
                   + {right_post_bq[23], right_post_bq};
   assign rate_wr  = s_q.rate[`PWMRT_RATE_LSB +: 4];
   assign rate_ok  = (rate_wr >= `PWMRT_RATE_MIN)
                  && (rate_wr <= `PWMRT_RATE_MAX);

   // Next state: register writes, reads, routing and the sample path
   always_comb begin
      s_d       = s_q;
      s_d.ack   = reg_wr | reg_rd;
      s_d.pin   = pin_sel;
      if (reg_wr) begin
         case (reg_addr)
            `PWMRT_OFS_CH4_SRC: s_d.ch4_src = reg_wdata;
            `PWMRT_OFS_XBAR:    s_d.xbar    = reg_wdata;
            `PWMRT_OFS_DRC_EN:  s_d.drc_en  = reg_wdata;
            `PWMRT_OFS_RATE:    s_d.rate    = reg_wdata;
            default:            s_d.ch4_src = s_q.ch4_src;
         endcase
      end
      // Unmapped addresses read as zero
      if (reg_rd) begin
         case (reg_addr)
            `PWMRT_OFS_CH4_SRC: s_d.rdata = s_q.ch4_src;
            `PWMRT_OFS_XBAR:    s_d.rdata = s_q.xbar;
            `PWMRT_OFS_DRC_EN:  s_d.rdata = s_q.drc_en;
            `PWMRT_OFS_RATE:    s_d.rdata = s_q.rate;
            default:            s_d.rdata = 32'h0000_0000;
         endcase
      end
      if (sample_valid) begin
         if (s_q.ch4_src[`PWMRT_CH4_SEL_BIT]) begin
            s_d.ch4_sample = left_post_bq;
         end else begin
            s_d.ch4_sample = pwmrt_sample_t'(sum_wide[24:1]);
         end
      end
      // Flags a reserved code left in the register; it is never applied
      s_d.rate_bad = !rate_ok;
      // Rate reaches the modulator only in shutdown, and only if valid,
      // so a switching modulator never sees its carrier change
      if (all_shutdown && rate_ok) begin
         s_d.rate_active = rate_wr;
      end
   end

   // State register
   always_ff @(posedge mclk or posedge rst) begin
      if (rst) begin
         s_q.ch4_src     <= `PWMRT_RST_CH4_SRC;
         s_q.xbar        <= `PWMRT_RST_XBAR;
         s_q.drc_en      <= `PWMRT_RST_DRC_EN;
         s_q.rate        <= `PWMRT_RST_RATE;
         s_q.rate_active <= `PWMRT_RATE_MIN;
         s_q.rate_bad    <= 1'b0;
         s_q.ch4_sample  <= 24'h00_0000;
         s_q.pin         <= 4'h0;
         s_q.rdata       <= 32'h0000_0000;
         s_q.ack         <= 1'b0;
      end else begin
         s_q <= s_d;
      end
   end

   // Outputs straight from the state flops
   assign reg_rdata_q           = s_q.rdata;
   assign reg_ack_q             = s_q.ack;
   assign fourth_channel_q      = s_q.ch4_sample;
   assign out_pin_q             = s_q.pin;
   assign first_compressor_q    = s_q.drc_en[`PWMRT_FIRST_COMPRESSOR_BIT];
   assign second_compressor_q   = s_q.drc_en[`PWMRT_SECOND_COMPRESSOR_BIT];
   assign switching_rate_code_q = s_q.rate_active;
   assign rate_code_bad_q       = s_q.rate_bad;

   // Expected pin level for a code, by the crossbar table
   function automatic logic exp_pin(input logic [1:0] c,
                                    input logic [1:0] ch);
      exp_pin = c[0] ? ch[1] : ch[0];
   endfunction : exp_pin

   a_ch4_left_pick: assert property (@(posedge mclk)
      disable iff (rst)
      sample_valid && s_q.ch4_src[8]
      |=> fourth_channel_q == $past(left_post_bq))
      else $error("fourth channel not left sample");
   // Sum minus twice the result must be 0 or 1: floor, and no wrap
   a_ch4_avg_value: assert property (@(posedge mclk)
      disable iff (rst)
      sample_valid && !s_q.ch4_src[8]
      |=> $past({{2{left_post_bq[23]}}, left_post_bq}
                + {{2{right_post_bq[23]}}, right_post_bq})
          - {fourth_channel_q[23], fourth_channel_q, 1'b0}
          inside {26'h000_0000, 26'h000_0001})
      else $error("fourth channel average wrong");
   a_ch4_hold_idle: assert property (@(posedge mclk)
      disable iff (rst)
      !sample_valid |=> $stable(fourth_channel_q))
      else $error("fourth channel moved without sample");
   a_xbar_pin_a: assert property (@(posedge mclk)
      disable iff (rst)
      out_pin_q[0] == $past(exp_pin(s_q.xbar[21:20], pwm_ch)))
      else $error("pin A routing wrong");
   a_xbar_pin_b: assert property (@(posedge mclk)
      disable iff (rst)
      out_pin_q[1] == $past(exp_pin(s_q.xbar[17:16], pwm_ch)))
      else $error("pin B routing wrong");
   a_xbar_pin_c: assert property (@(posedge mclk)
      disable iff (rst)
      out_pin_q[2] == $past(exp_pin(s_q.xbar[13:12], pwm_ch)))
      else $error("pin C routing wrong");
   a_xbar_pin_d: assert property (@(posedge mclk)
      disable iff (rst)
      out_pin_q[3] == $past(exp_pin(s_q.xbar[9:8], pwm_ch)))
      else $error("pin D routing wrong");
   a_xbar_write_sel: assert property (@(posedge mclk)
      disable iff (rst)
      reg_wr && reg_addr == 8'h25 |=> s_q.xbar == $past(reg_wdata))
      else $error("crossbar write lost");
   a_drc_enables: assert property (@(posedge mclk)
      disable iff (rst)
      reg_wr && reg_addr == 8'h46
      |=> first_compressor_q == $past(reg_wdata[0])
          && second_compressor_q == $past(reg_wdata[1]))
      else $error("compressor enable wrong");
   a_drc_first_hold: assert property (@(posedge mclk)
      disable iff (rst)
      !(reg_wr && reg_addr == 8'h46) |=> $stable(first_compressor_q))
      else $error("first compressor changed alone");
   a_drc_second_hold: assert property (@(posedge mclk)
      disable iff (rst)
      !(reg_wr && reg_addr == 8'h46) |=> $stable(second_compressor_q))
      else $error("second compressor changed alone");
   a_rate_only_valid: assert property (@(posedge mclk)
      disable iff (rst)
      switching_rate_code_q inside {4'h6, 4'h7, 4'h8, 4'h9})
      else $error("invalid rate applied");
   a_rate_run_hold: assert property (@(posedge mclk)
      disable iff (rst)
      !all_shutdown |=> $stable(switching_rate_code_q))
      else $error("rate changed while running");
   a_rate_take_code: assert property (@(posedge mclk)
      disable iff (rst)
      all_shutdown && rate_ok |=> switching_rate_code_q == $past(rate_wr))
      else $error("rate not taken in shutdown");
   a_rate_bad_flag: assert property (@(posedge mclk)
      disable iff (rst)
      rate_code_bad_q == $past(s_q.rate[3:0] < 4'h6 || s_q.rate[3:0] > 4'h9))
      else $error("reserved rate code not flagged");
   a_read_ack_next: assert property (@(posedge mclk)
      disable iff (rst)
      reg_rd && reg_addr == 8'h4F
      |=> reg_ack_q && reg_rdata_q == $past(s_q.rate))
      else $error("rate readback wrong");

   c_avg_source: cover property (@(posedge mclk) disable iff (rst)
      sample_valid && !s_q.ch4_src[8]);
   c_pin_a_ch2: cover property (@(posedge mclk) disable iff (rst)
      s_q.xbar[21:20] == 2'h3 && pwm_ch[1]);
   c_both_drc: cover property (@(posedge mclk) disable iff (rst)
      first_compressor_q && second_compressor_q);
   c_rate_nine: cover property (@(posedge mclk) disable iff (rst)
      switching_rate_code_q == 4'h9);

endmodule : pwmrt_core

// ==== inc/pwmrt_regs.svh ====
// Register offsets, field positions and reset values of the PWM output
// routing block. Included by the package, the core and the testbench.
`ifndef PWMRT_REGS_SVH
`define PWMRT_REGS_SVH

// Register offsets on the serial control port
`define PWMRT_OFS_CH4_SRC   8'h21
`define PWMRT_OFS_XBAR      8'h25
`define PWMRT_OFS_DRC_EN    8'h46
`define PWMRT_OFS_RATE      8'h4F

// Field positions
`define PWMRT_CH4_SEL_BIT   8
`define PWMRT_XBAR_A_LSB    20
`define PWMRT_XBAR_B_LSB    16
`define PWMRT_XBAR_C_LSB    12
`define PWMRT_XBAR_D_LSB    8
`define PWMRT_SECOND_COMPRESSOR_BIT      1
`define PWMRT_FIRST_COMPRESSOR_BIT      0
`define PWMRT_RATE_LSB      0

// Reset values, reserved bits at their defaults
`define PWMRT_RST_CH4_SRC   32'h0000_4303
`define PWMRT_RST_XBAR      32'h0102_1345
`define PWMRT_RST_DRC_EN    32'h0000_0000
`define PWMRT_RST_RATE      32'h0000_0006

// Valid switching-rate codes
`define PWMRT_RATE_MIN      4'h6
`define PWMRT_RATE_MAX      4'h9

`endif

// ==== inc/pwmrt_pkg.sv ====
// Types shared by the PWM output routing block.
// Assumes pwmrt_regs.svh is on the include path.
`include "pwmrt_regs.svh"

package pwmrt_pkg;

   // Audio sample after the biquad stages
   typedef logic signed [23:0] pwmrt_sample_t;

   // Complete state of the core
   typedef struct packed {
      logic [31:0]   ch4_src;
      logic [31:0]   xbar;
      logic [31:0]   drc_en;
      logic [31:0]   rate;
      logic [3:0]    rate_active;
      logic          rate_bad;
      pwmrt_sample_t ch4_sample;
      logic [3:0]    pin;
      logic [31:0]   rdata;
      logic          ack;
   } pwmrt_state_t;

endpackage : pwmrt_pkg

// ==== src/pwmrt_pin_sel.sv ====
// One output pin of the crossbar: picks an internal PWM channel by code.
// Assumes the code comes from a register and the channels are in-clock.
module pwmrt_pin_sel (
   // Selection
   input  wire logic [1:0] code,
   // Internal PWM channels 1 and 2
   input  wire logic [1:0] ch,
   // Selected level
   output logic            pin
);

   // 00 and 01 name channels 1 and 2; 10 and 11 alias them again
   always_comb begin
      case (code)
         2'h0:    pin = ch[0];
         2'h1:    pin = ch[1];
         2'h2:    pin = ch[0];
         2'h3:    pin = ch[1];
         default: pin = ch[0];
      endcase
   end

endmodule : pwmrt_pin_sel

// ==== test/pwmrt_core_tb.sv ====
// Self-checking bench for the PWM output routing core.
// Assumes pwmrt_pkg and pwmrt_regs.svh are compiled and on the path.
`include "pwmrt_regs.svh"
module pwmrt_core_tb;
   timeunit 1ns;
   timeprecision 1ns;
   import pwmrt_pkg::*;

   logic          mclk = 0, rst = 1, reg_wr = 0, reg_rd = 0;
   logic          sample_valid = 0, all_shutdown = 0;
   logic [7:0]    reg_addr = 8'h00;
   logic [31:0]   reg_wdata = 32'h0, reg_rdata_q, rd;
   logic          reg_ack_q, first_compressor_q, second_compressor_q;
   logic          rate_code_bad_q;
   logic [1:0]    pwm_ch = 2'h0;
   logic [3:0]    out_pin_q, switching_rate_code_q, e;
   pwmrt_sample_t left_post_bq = '0, right_post_bq = '0, fourth_channel_q;
   int            failures = 0, n_checks = 0, c, p;

   // 10 MHz clock
   always #50 mclk = ~mclk;

   pwmrt_core dut (.mclk(mclk), .rst(rst), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata_q(reg_rdata_q),
      .reg_ack_q(reg_ack_q), .sample_valid(sample_valid),
      .left_post_bq(left_post_bq), .right_post_bq(right_post_bq),
      .fourth_channel_q(fourth_channel_q), .pwm_ch(pwm_ch),
      .out_pin_q(out_pin_q), .all_shutdown(all_shutdown),
      .first_compressor_q(first_compressor_q),
      .second_compressor_q(second_compressor_q),
      .switching_rate_code_q(switching_rate_code_q),
      .rate_code_bad_q(rate_code_bad_q));

   // Compare and count
   task chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   // One strobe cycle; ack must follow exactly one cycle later
   task bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
      @(posedge mclk);
      reg_wr <= wr;
      reg_rd <= !wr;
      reg_addr <= a;
      reg_wdata <= d;
      @(posedge mclk);
      reg_wr <= 1'b0;
      reg_rd <= 1'b0;
      @(negedge mclk);
      chk({31'h0, reg_ack_q}, 32'h1);
      rd = reg_rdata_q;
   endtask : bus

   task rdchk(input logic [7:0] a, input logic [31:0] exp);
      bus(1'b0, a, 32'h0);
      chk(rd, exp);
   endtask : rdchk

   // Pins are registered one cycle after the channels
   task pins(input logic [1:0] ch, input logic [3:0] exp);
      @(posedge mclk);
      pwm_ch <= ch;
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      chk({28'h0, out_pin_q}, {28'h0, exp});
   endtask : pins

   task smp(input pwmrt_sample_t l, input pwmrt_sample_t r,
            input pwmrt_sample_t exp);
      @(posedge mclk);
      sample_valid <= 1'b1;
      left_post_bq <= l;
      right_post_bq <= r;
      @(posedge mclk);
      sample_valid <= 1'b0;
      @(negedge mclk);
      chk({8'h0, fourth_channel_q}, {8'h0, exp});
   endtask : smp

   task print_verdict;
      $display("checks=%0d failures=%0d", n_checks, failures);
      if (failures == 0 && n_checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask : print_verdict

   // Cuts a hang short; the tests need well under 1000 cycles
   initial begin
      #(3000 * 100);
      failures++;
      print_verdict();
   end

   initial begin
      repeat (16) @(posedge mclk);
      rst <= 1'b0;
      // Reset values, unmapped read gives zero
      rdchk(`PWMRT_OFS_CH4_SRC, `PWMRT_RST_CH4_SRC);
      rdchk(`PWMRT_OFS_XBAR, `PWMRT_RST_XBAR);
      rdchk(`PWMRT_OFS_DRC_EN, 32'h0);
      rdchk(`PWMRT_OFS_RATE, 32'h6);
      rdchk(8'h30, 32'h0);
      chk({30'h0, second_compressor_q, first_compressor_q}, 32'h0);
      chk({28'h0, switching_rate_code_q}, 32'h6);
      pins(2'b10, 4'b1100);
      pins(2'b01, 4'b0011);
      $display("test reset done");
      // Every code on every pin, fields staggered to catch swaps
      for (c = 0; c < 4; c++) begin
         bus(1'b1, `PWMRT_OFS_XBAR, 32'h0100_0045 | (c << 20)
             | (((c + 1) % 4) << 16) | (((c + 2) % 4) << 12)
             | (((c + 3) % 4) << 8));
         for (p = 0; p < 4; p++) e[p] = ((c + p) % 2 == 0) ? 1'b1 : 1'b0;
         pins(2'b01, e);
         pins(2'b10, ~e);
      end
      $display("test crossbar done");
      // Compressor enables, each combination
      for (c = 0; c < 5; c++) begin
         bus(1'b1, `PWMRT_OFS_DRC_EN, c % 4);
         chk({30'h0, second_compressor_q, first_compressor_q},
             c % 4);
      end
      $display("test compressor done");
      // Fourth channel: left by default, then average with floor
      smp(24'h123456, 24'h000001, 24'h123456);
      bus(1'b1, `PWMRT_OFS_CH4_SRC, 32'h0000_4203);
      smp(24'h000004, 24'hFFFFFF, 24'h000001);
      smp(24'h7FFFFF, 24'h7FFFFF, 24'h7FFFFF);
      smp(24'h800000, 24'h800000, 24'h800000);
      smp(24'hFFFFFD, 24'h000000, 24'hFFFFFE);
      $display("test fourth channel done");
      // Rate code applied only in shutdown and only when valid
      bus(1'b1, `PWMRT_OFS_RATE, 32'h8);
      repeat (3) @(posedge mclk);
      @(negedge mclk);
      chk({28'h0, switching_rate_code_q}, 32'h6);
      rdchk(`PWMRT_OFS_RATE, 32'h8);
      @(posedge mclk);
      all_shutdown <= 1'b1;
      for (c = 6; c < 13; c++) begin
         bus(1'b1, `PWMRT_OFS_RATE, c);
         repeat (2) @(posedge mclk);
         @(negedge mclk);
         chk({28'h0, switching_rate_code_q}, (c > 9) ? 9 : c);
         chk({31'h0, rate_code_bad_q}, (c > 9) ? 1 : 0);
      end
      // Leaving shutdown freezes the applied code
      @(posedge mclk);
      all_shutdown <= 1'b0;
      bus(1'b1, `PWMRT_OFS_RATE, 32'h7);
      repeat (2) @(posedge mclk);
      @(negedge mclk);
      chk({28'h0, switching_rate_code_q}, 32'h9);
      chk({31'h0, rate_code_bad_q}, 32'h0);
      $display("test switching rate done");
      print_verdict();
   end
endmodule : pwmrt_core_tb
